// [logic/cpc_pair_buf.sv]
/*
  cpc_pair_buf: two-entry byte buffer with valid/ready on both sides.
  Assumes both sides run on the same clock.
*/
module cpc_pair_buf
  import cpc_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // fill side
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [BYTE_W-1:0] in_data,
  // drain side
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [BYTE_W-1:0]      out_data
);
  logic [BYTE_W-1:0] mem_q [BUF_DEPTH];
  logic              wp_q;
  logic              rp_q;
  logic [1:0]        cnt_q;
  logic              push;
  logic              pop;

  // honest full/empty straight from the count
  assign in_ready  = cnt_q != BUF_FULL;
  assign out_valid = cnt_q != 2'h0;
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage needs no reset; only the pointers and count do
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk) begin
    if (reset) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wp_q <= ~wp_q;
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : cpc_pair_buf

// [logic/cpc_pin_ctrl.sv]
/*
  cpc_pin_ctrl: configuration-port pin control with test access port.
  Assumes pads resolve in/out/oe triples and a loader drains load_*.
*/
module cpc_pin_ctrl
  import cpc_pkg::*;
(
  // system
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // mode and program pins
  input  wire logic [2:0]        mode_select,
  input  wire logic              program_request_n,
  // open-drain ready and done pins
  input  wire logic              config_ready_n_in,
  output logic                   config_ready_n_out,
  output logic                   config_ready_n_oe,
  input  wire logic              config_done_in,
  output logic                   config_done_out,
  output logic                   config_done_oe,
  // configuration clock pin
  input  wire logic              config_clock_in,
  output logic                   config_clock_out,
  output logic                   config_clock_oe,
  // handshake and serial-out pins
  input  wire logic              handshake_multi_pin_in,
  output logic                   handshake_multi_pin_out,
  output logic                   handshake_multi_pin_oe,
  output logic                   serial_out_or_flash_select,
  output logic                   serial_out_oe,
  // host select and direction pins
  input  wire logic              primary_chip_select_n,
  input  wire logic              second_chip_select_n,
  input  wire logic              parallel_write_enable_n,
  // data pins, bit 0 is config_data_bit0
  input  wire logic [7:0]        config_data_in,
  output logic      [7:0]        config_data_out,
  output logic      [7:0]        config_data_oe,
  // user logic side of shared pins
  input  wire logic [7:0]        user_data_out,
  input  wire logic [7:0]        user_data_oe,
  input  wire logic              user_hs_out,
  input  wire logic              user_hs_oe,
  input  wire logic              user_so_out,
  input  wire logic              user_so_oe,
  // test access port
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  // configuration byte stream to the loader
  output logic [BYTE_W-1:0]      load_data,
  output logic                   load_valid,
  input  wire logic              load_ready,
  input  wire logic              load_finished,
  // status
  output logic                   config_active,
  output logic [2:0]             captured_mode,
  output logic [1:0]             locked_port,
  output logic                   data_overrun,
  output logic                   startup_done
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] s1_q, s2_q;
  logic              rdy_d_q, config_clock_d_q;
  cpc_seq_t          seq_q;
  cpc_port_t         lock_q;
  logic [5:0]        clr_q, hdr_q;
  logic [2:0]        mode_q, bc_q, dv_q;
  logic [7:0]        sh_q, pb_q, din_s;
  logic [31:0]       cmd_q;
  logic              ovr_q, pv_q, mclk_q, jack_q;
  logic              prog_s, rdy_s, cs_s, cs1_s, wr_s, config_clock_s, jreq_s;
  logic              rdy_rise, s_rise, loading, pin_cfg, is_mst, is_par;
  logic              jpend, jtake, mrun, ser_stb, ser_bit, hdr_skip;
  logic              par_stb, bi_valid, bi_ready;
  logic [7:0]        bi_data, status;
  // test clock domain
  logic              rt1_q, rt2_q, ja1_q, ja2_q, jreq_q, tdo_q, jbusy;
  logic [3:0]        ir_sh_q, ir_q;
  logic [7:0]        dr_q, jbyte_q;
  cpc_tap_t          tap_q, tap_d;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // every pin and test-domain flag crosses two flops before use
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
    end else begin
      s1_q <= {mode_select, program_request_n, config_ready_n_in,
               config_done_in, config_clock_in, primary_chip_select_n,
               second_chip_select_n, parallel_write_enable_n, jreq_q,
               config_data_in};
      s2_q <= s1_q;
    end
  end

  // delayed copies for edge detection, taken from the second stage
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdy_d_q  <= 1'b1;
      config_clock_d_q <= 1'b1;
    end else begin
      rdy_d_q  <= rdy_s;
      config_clock_d_q <= config_clock_s;
    end
  end

  assign prog_s   = s2_q[SI_PROG];
  assign rdy_s    = s2_q[SI_RDY];
  assign config_clock_s   = s2_q[SI_CONFIG_CLOCK];
  assign cs_s     = s2_q[SI_CS];
  assign cs1_s    = s2_q[SI_CS1];
  assign wr_s     = s2_q[SI_WR];
  assign jreq_s   = s2_q[SI_JREQ];
  assign din_s    = s2_q[7:0];
  assign rdy_rise = rdy_s & ~rdy_d_q;
  assign s_rise   = config_clock_s & ~config_clock_d_q;

  // ---------------------------------------------------------------
  // configuration sequence
  // ---------------------------------------------------------------
  // program low wins over every state and restarts the clear phase
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      seq_q <= SQ_CLEAR;
      clr_q <= 6'h00;
    end else if (!prog_s) begin
      seq_q <= SQ_CLEAR;
      clr_q <= 6'h00;
    end else begin
      case (seq_q)
        SQ_CLEAR: begin
          if (clr_q == CLEAR_LAST) seq_q <= SQ_WAIT;
          else clr_q <= clr_q + 6'h01;
        end
        SQ_WAIT: begin
          if (rdy_rise || jtake) seq_q <= SQ_LOAD;
          clr_q <= 6'h00;
        end
        SQ_LOAD: begin
          if (load_finished) seq_q <= SQ_DONE;
        end
        SQ_DONE: seq_q <= SQ_DONE;
        default: seq_q <= SQ_CLEAR;
      endcase
    end
  end

  // mode latched only on the ready rising edge, held otherwise
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_q <= MODE_RST;
    end else if (prog_s && seq_q == SQ_WAIT && rdy_rise) begin
      mode_q <= s2_q[SI_MODE +: 3];
    end
  end

  // lock is cleared by reset alone, never by a program request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lock_q <= PORT_NONE;
    end else if (lock_q == PORT_NONE) begin
      if (pv_q) lock_q <= PORT_PINS;
      else if (jtake) lock_q <= PORT_JTAG;
    end
  end

  // overrun: a serial or parallel pin byte with no room; set wins over clear
  always_ff @(posedge ref_clk) begin
    if (reset) ovr_q <= 1'b0;
    else if (pv_q && !bi_ready) ovr_q <= 1'b1;
    else if (!prog_s) ovr_q <= 1'b0;
  end

  assign loading = seq_q == SQ_LOAD;
  assign pin_cfg = loading && lock_q != PORT_JTAG;
  assign is_mst  = mode_q == MODE_MSPI || mode_q == MODE_MSER;
  assign is_par  = mode_q == MODE_PAR;
  assign config_ready_n_out = 1'b0;
  assign config_ready_n_oe  = seq_q == SQ_CLEAR;
  assign config_done_out    = 1'b0;
  assign config_done_oe     = seq_q != SQ_DONE;
  assign config_active = loading;
  assign captured_mode = mode_q;
  assign locked_port   = lock_q;
  assign data_overrun  = ovr_q;
  assign startup_done  = seq_q == SQ_DONE && s2_q[SI_DONE];

  // ---------------------------------------------------------------
  // serial and parallel engines
  // ---------------------------------------------------------------
  // master clock stalls while the buffer is full: no byte is lost
  assign mrun = pin_cfg && is_mst && bi_ready && !pv_q;
  assign ser_bit  = mode_q == MODE_MSPI ? din_s[1] : din_s[0];
  assign hdr_skip = mode_q == MODE_MSPI && hdr_q != SPI_HDR_BITS;
  assign ser_stb  = pin_cfg && (is_mst
                    ? (mrun && mclk_q && dv_q == MCLK_LAST)
                    : (mode_q == MODE_SSER || (mode_q == MODE_SSPI && !cs_s))
                      && s_rise);
  assign par_stb  = pin_cfg && is_par && !cs_s && !cs1_s && !wr_s
                    && s_rise;

  // master clock divider; data sampled as the clock falls
  always_ff @(posedge ref_clk) begin
    if (reset || !loading) begin
      dv_q   <= 3'h0;
      mclk_q <= 1'b0;
    end else if (mrun) begin
      if (dv_q == MCLK_LAST) begin
        dv_q   <= 3'h0;
        mclk_q <= ~mclk_q;
      end else begin
        dv_q <= dv_q + 3'h1;
      end
    end
  end

  // bit shifter; flash read header goes out before data is kept
  always_ff @(posedge ref_clk) begin
    if (reset || !loading) begin
      sh_q  <= 8'h00;
      bc_q  <= 3'h0;
      hdr_q <= 6'h00;
      cmd_q <= FLASH_READ_HDR;
    end else if (ser_stb) begin
      cmd_q <= {cmd_q[30:0], 1'b0};
      if (hdr_skip) begin
        hdr_q <= hdr_q + 6'h01;
      end else begin
        sh_q <= {sh_q[6:0], ser_bit};
        bc_q <= bc_q + 3'h1;
      end
    end
  end

  // one-cycle byte strobe from either pin engine
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pv_q <= 1'b0;
      pb_q <= 8'h00;
    end else begin
      pv_q <= 1'b0;
      if (ser_stb && !hdr_skip && bc_q == 3'h7) begin
        pv_q <= 1'b1;
        pb_q <= {sh_q[6:0], ser_bit};
      end else if (par_stb) begin
        pv_q <= 1'b1;
        pb_q <= din_s;
      end
    end
  end

  // ---------------------------------------------------------------
  // test-port byte handshake and buffer
  // ---------------------------------------------------------------
  // jbyte_q is steady while a request is open, so it is read directly
  assign jpend = jreq_s != jack_q;
  assign jtake = jpend && bi_ready && !pv_q && lock_q != PORT_PINS
                 && (seq_q == SQ_WAIT || loading);
  assign bi_valid = pv_q | jtake;
  assign bi_data  = pv_q ? pb_q : jbyte_q;

  // acknowledge toggle closes the request
  always_ff @(posedge ref_clk) begin
    if (reset) jack_q <= 1'b0;
    else if (jtake) jack_q <= jreq_s;
  end

  cpc_pair_buf u_buf (
    .clk       (ref_clk),
    .reset     (reset),
    .in_valid  (bi_valid),
    .in_ready  (bi_ready),
    .in_data   (bi_data),
    .out_valid (load_valid),
    .out_ready (load_ready),
    .out_data  (load_data)
  );

  // ---------------------------------------------------------------
  // shared pin steering
  // ---------------------------------------------------------------
  // parallel readback drives zeros only where a status bit is low
  assign status = {6'h00, ovr_q, ~bi_ready};

  always_comb begin
    config_data_out            = user_data_out;
    config_data_oe             = user_data_oe;
    handshake_multi_pin_out    = user_hs_out;
    handshake_multi_pin_oe     = user_hs_oe;
    serial_out_or_flash_select = user_so_out;
    serial_out_oe              = user_so_oe;
    config_clock_out           = 1'b0;
    config_clock_oe            = 1'b0;
    if (pin_cfg) begin
      config_data_out            = 8'h00;
      config_data_oe             = 8'h00;
      handshake_multi_pin_out    = sh_q[7];
      handshake_multi_pin_oe     = 1'b1;
      serial_out_or_flash_select = sh_q[7];
      serial_out_oe              = 1'b1;
      if (is_mst) begin
        config_clock_out = mclk_q;
        config_clock_oe  = 1'b1;
        config_data_oe[0]  = mode_q == MODE_MSPI;
        config_data_out[0] = cmd_q[31];
      end
      if (mode_q == MODE_MSPI) serial_out_or_flash_select = 1'b0;
      if (is_par) begin
        handshake_multi_pin_out = ~bi_ready;
        if (!cs_s && !cs1_s && wr_s) config_data_oe = ~status;
      end
    end
  end

  // ---------------------------------------------------------------
  // test access port (tck domain)
  // ---------------------------------------------------------------
  // reset and acknowledge enter the test clock domain through two flops
  always_ff @(posedge tck) begin
    rt1_q <= reset;
    rt2_q <= rt1_q;
    ja1_q <= jack_q;
    ja2_q <= ja1_q;
  end

  assign jbusy = jreq_q != ja2_q;

  // state machine steered by TMS on each rising test clock
  always_comb begin
    case (tap_q)
      TP_TLR:  tap_d = tms ? TP_TLR  : TP_RTI;
      TP_RTI:  tap_d = tms ? TP_SDR  : TP_RTI;
      TP_SDR:  tap_d = tms ? TP_SIR  : TP_CDR;
      TP_CDR:  tap_d = tms ? TP_E1DR : TP_SHDR;
      TP_SHDR: tap_d = tms ? TP_E1DR : TP_SHDR;
      TP_E1DR: tap_d = tms ? TP_UDR  : TP_PDR;
      TP_PDR:  tap_d = tms ? TP_E2DR : TP_PDR;
      TP_E2DR: tap_d = tms ? TP_UDR  : TP_SHDR;
      TP_UDR:  tap_d = tms ? TP_SDR  : TP_RTI;
      TP_SIR:  tap_d = tms ? TP_TLR  : TP_CIR;
      TP_CIR:  tap_d = tms ? TP_E1IR : TP_SHIR;
      TP_SHIR: tap_d = tms ? TP_E1IR : TP_SHIR;
      TP_E1IR: tap_d = tms ? TP_UIR  : TP_PIR;
      TP_PIR:  tap_d = tms ? TP_E2IR : TP_PIR;
      TP_E2IR: tap_d = tms ? TP_UIR  : TP_SHIR;
      TP_UIR:  tap_d = tms ? TP_SDR  : TP_RTI;
      default: tap_d = TP_TLR;
    endcase
  end

  always_ff @(posedge tck) begin
    if (rt2_q) tap_q <= TP_TLR;
    else tap_q <= tap_d;
  end

  // instruction register, shifted in least significant bit first
  always_ff @(posedge tck) begin
    if (rt2_q || tap_q == TP_TLR) begin
      ir_sh_q <= IR_CAPTURE;
      ir_q    <= IR_BYPASS;
    end else if (tap_q == TP_CIR) begin
      ir_sh_q <= IR_CAPTURE;
    end else if (tap_q == TP_SHIR) begin
      ir_sh_q <= {tdi, ir_sh_q[3:1]};
    end else if (tap_q == TP_UIR) begin
      ir_q <= ir_sh_q;
    end
  end

  // data register; capture shows busy so the tester can pace bytes
  always_ff @(posedge tck) begin
    if (rt2_q) begin
      dr_q    <= 8'h00;
      jbyte_q <= 8'h00;
      jreq_q  <= 1'b0;
    end else if (tap_q == TP_CDR) begin
      dr_q <= {7'h00, jbusy};
    end else if (tap_q == TP_SHDR) begin
      dr_q <= ir_q == IR_CFG_LOAD ? {tdi, dr_q[7:1]} : {7'h00, tdi};
    end else if (tap_q == TP_UDR && ir_q == IR_CFG_LOAD && !jbusy) begin
      jbyte_q <= dr_q;
      jreq_q  <= ~jreq_q;
    end
  end

  // output changes on the falling test clock edge
  always_ff @(negedge tck) begin
    if (rt2_q) tdo_q <= 1'b0;
    else tdo_q <= tap_q == TP_SHIR ? ir_sh_q[0] : dr_q[0];
  end

  assign tdo = tdo_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_mode_cap;
    @(posedge ref_clk) disable iff (reset)
      (prog_s && seq_q == SQ_WAIT && rdy_rise)
      |=> mode_q == $past(s2_q[SI_MODE +: 3]);
  endproperty
  a_mode_cap: assert property (p_mode_cap) else $error("mode");

  property p_prog;
    @(posedge ref_clk) disable iff (reset)
      !prog_s |=> config_ready_n_oe && !config_active;
  endproperty
  a_prog: assert property (p_prog) else $error("program");

  property p_ready;
    @(posedge ref_clk) disable iff (reset)
      $fell(config_ready_n_oe) |-> $past(clr_q) == CLEAR_LAST;
  endproperty
  a_ready: assert property (p_ready) else $error("ready");

  property p_done;
    @(posedge ref_clk) disable iff (reset)
      (prog_s && loading && load_finished) |=> !config_done_oe;
  endproperty
  a_done: assert property (p_done) else $error("done");

  property p_config_clock;
    @(posedge ref_clk) disable iff (reset)
      config_clock_oe |-> pin_cfg && is_mst;
  endproperty
  a_config_clock: assert property (p_config_clock) else $error("clock dir");

  property p_lock;
    @(posedge ref_clk) disable iff (reset)
      lock_q != PORT_NONE |=> $stable(lock_q);
  endproperty
  a_lock: assert property (p_lock) else $error("lock");

  property p_tap_reset;
    @(posedge tck) disable iff (rt2_q) tms [*5] |=> tap_q == TP_TLR;
  endproperty
  a_tap_reset: assert property (p_tap_reset) else $error("tap");

  property p_mosi;
    @(posedge ref_clk) disable iff (reset)
      (pin_cfg && mode_q == MODE_MSPI && ser_stb)
      |=> config_data_out[0] == $past(cmd_q[30]) || !pin_cfg;
  endproperty
  a_mosi: assert property (p_mosi) else $error("mosi");

  property p_od;
    @(posedge ref_clk) disable iff (reset)
      (pin_cfg && is_par) |-> config_data_out == 8'h00;
  endproperty
  a_od: assert property (p_od) else $error("open drain");

  property p_busy;
    @(posedge ref_clk) disable iff (reset)
      (pin_cfg && is_par) |-> handshake_multi_pin_out == !bi_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("busy");

  property p_hold;
    @(posedge ref_clk) disable iff (reset)
      !(seq_q == SQ_WAIT && rdy_rise) |=> $stable(mode_q);
  endproperty
  a_hold: assert property (p_hold) else $error("mode moved");
endmodule : cpc_pin_ctrl

// [logic/cpc_pkg.sv]
/*
  cpc_pkg: constants and types of the configuration-port pin control.
  Assumes a 40 MHz ref_clk and a test clock from the boundary-scan tester.
*/
package cpc_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS        = 25;
  localparam int CLEAR_NS      = 1000;
  localparam int CLEAR_CYC     = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
  localparam int MCLK_HALF_NS  = 100;
  localparam int MCLK_HALF_CYC = (MCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [5:0] CLEAR_LAST = 6'(CLEAR_CYC - 1);
  localparam logic [2:0] MCLK_LAST  = 3'(MCLK_HALF_CYC - 1);
  // ---------------------------------------------------------------
  // modes, flash header, sizes
  // ---------------------------------------------------------------
  localparam logic [2:0]  MODE_MSPI      = 3'h0;
  localparam logic [2:0]  MODE_SSPI      = 3'h1;
  localparam logic [2:0]  MODE_PAR       = 3'h2;
  localparam logic [2:0]  MODE_SSER      = 3'h3;
  localparam logic [2:0]  MODE_MSER      = 3'h4;
  localparam logic [2:0]  MODE_RST       = 3'h7;
  localparam logic [5:0]  SPI_HDR_BITS   = 6'h20;
  localparam logic [31:0] FLASH_READ_HDR = 32'h0300_0000;
  localparam int          BYTE_W         = 8;
  localparam int          BUF_DEPTH      = 2;
  localparam logic [1:0]  BUF_FULL       = 2'h2;
  // ---------------------------------------------------------------
  // synchroniser vector layout
  // ---------------------------------------------------------------
  localparam int SYNC_W = 19;
  localparam logic [SYNC_W-1:0] SYNC_RST = 19'h7_FFFF;
  localparam int SI_MODE = 16;
  localparam int SI_PROG = 15;
  localparam int SI_RDY  = 14;
  localparam int SI_DONE = 13;
  localparam int SI_CONFIG_CLOCK = 12;
  localparam int SI_CS   = 11;
  localparam int SI_CS1  = 10;
  localparam int SI_WR   = 9;
  localparam int SI_JREQ = 8;
  // ---------------------------------------------------------------
  // test port
  // ---------------------------------------------------------------
  localparam logic [3:0] IR_CAPTURE  = 4'h1;
  localparam logic [3:0] IR_BYPASS   = 4'hF;
  localparam logic [3:0] IR_CFG_LOAD = 4'h5;
  typedef enum logic [1:0] {
    SQ_CLEAR = 2'b00, SQ_WAIT = 2'b01, SQ_LOAD = 2'b10, SQ_DONE = 2'b11
  } cpc_seq_t;
  typedef enum logic [1:0] {
    PORT_NONE = 2'b00, PORT_PINS = 2'b01, PORT_JTAG = 2'b10
  } cpc_port_t;
  typedef enum logic [3:0] {
    TP_TLR  = 4'b0000, TP_RTI  = 4'b0001, TP_SDR  = 4'b0010,
    TP_CDR  = 4'b0011, TP_SHDR = 4'b0100, TP_E1DR = 4'b0101,
    TP_PDR  = 4'b0110, TP_E2DR = 4'b0111, TP_UDR  = 4'b1000,
    TP_SIR  = 4'b1001, TP_CIR  = 4'b1010, TP_SHIR = 4'b1011,
    TP_E1IR = 4'b1100, TP_PIR  = 4'b1101, TP_E2IR = 4'b1110,
    TP_UIR  = 4'b1111
  } cpc_tap_t;
endpackage : cpc_pkg

// [test/cpc_host_model.sv]
/*
  cpc_host_model: parallel configuration host for the pin control.
  Assumes the caller waits for busy low before each send.
*/
module cpc_host_model (
  // timing reference
  input  wire logic  clk,
  // host pins
  output logic       config_clock,
  output logic       cs_n,
  output logic       cs1_n,
  output logic       wr_n,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------
  // byte write
  // ------------------------------------------
  initial begin
    {config_clock, cs_n, cs1_n, wr_n, data} = 12'h70F;
  end
  // clock still between bytes; data inverted once deselected
  task send(input logic [7:0] b);
    @(negedge clk);
    {cs_n, cs1_n, wr_n} = 3'h0;
    data = b;
    repeat (4) @(negedge clk);
    config_clock = 1'h1;
    repeat (4) @(negedge clk);
    config_clock = 1'h0;
    repeat (2) @(negedge clk);
    {cs_n, cs1_n, wr_n} = 3'h7;
    data = ~b;
  endtask : send
endmodule : cpc_host_model

// [test/cpc_pin_ctrl_test.sv]
/*
  cpc_pin_ctrl_test: parallel load, hand-back, master restart, test port.
  Assumes cpc_host_model as host; the bench plays the scan tester.
*/
module cpc_pin_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cpc_pkg::*;
  // ------------------------------------------
  // pins and state
  // ------------------------------------------
  logic       ref_clk = 0, reset = 1, tck = 0, tms = 1, tdi = 0;
  logic       program_request_n = 1, load_ready = 0, load_finished = 0;
  logic       handshake_multi_pin_in = 0, user_hs_out = 0, user_hs_oe = 0;
  logic       user_so_out = 0, user_so_oe = 0, serial_out_or_flash_select;
  logic       config_ready_n_in, config_done_in, config_clock_in;
  logic       primary_chip_select_n, second_chip_select_n;
  logic       parallel_write_enable_n, config_ready_n_oe, config_done_oe;
  logic       config_clock_oe, serial_out_oe, handshake_multi_pin_oe;
  logic       handshake_multi_pin_out, load_valid, config_active;
  logic       startup_done, config_ready_n_out, config_done_out;
  logic       config_clock_out, tdo, data_overrun;
  logic [2:0] mode_select = MODE_PAR, captured_mode;
  logic [1:0] locked_port;
  logic [7:0] user_data_out = 0, user_data_oe = 0, config_data_in, b;
  logic [7:0] config_data_out, config_data_oe, load_data, exp_q[$];
  logic [31:0] seed = 32'hD249;
  int         fail_count = 0, checks = 0;
  // open-drain pins with pull-ups
  assign config_ready_n_in = ~config_ready_n_oe;
  assign config_done_in = ~config_done_oe;
  cpc_host_model host (.clk(ref_clk), .config_clock(config_clock_in),
    .cs_n(primary_chip_select_n), .cs1_n(second_chip_select_n),
    .wr_n(parallel_write_enable_n), .data(config_data_in));
  cpc_pin_ctrl uut (.*);
  always #12.5 ref_clk = ~ref_clk;
  always #15 tck = ~tck;
  // ------------------------------------------
  // helpers
  // ------------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task check(input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %0t saw %h want %h", $time, s, e);
    end
  endtask : check
  task give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // bounded wait; running out ends the run
  task automatic wait_on(ref logic s, input logic v);
    for (int n = 0; n < 400 && s !== v; n++) @(negedge ref_clk);
    if (s !== v) begin
      fail_count++;
      give_verdict();
    end
  endtask : wait_on
  // bounded wait for the loader to take every noted byte
  task drain();
    for (int n = 0; n < 400 && exp_q.size() > 0; n++) @(negedge ref_clk);
    check(8'(exp_q.size()), 0);
    if (exp_q.size() > 0) give_verdict();
  endtask : drain
  // tester scan from reset: load instruction, then one data byte
  task jtag_load(input logic [7:0] d);
    logic [22:0] ts, td;
    ts = 23'h30_0706;
    td = {2'h0, d, 4'h0, IR_CFG_LOAD, 5'h00};
    repeat (4) @(negedge tck);
    for (int i = 0; i < 23; i++) begin
      @(negedge tck);
      if (i == 6) check(tdo, 1);
      tms = ts[i];
      tdi = td[i];
    end
  endtask : jtag_load
  // loader stalls at random so the buffer fills
  always @(negedge ref_clk) load_ready <= 1'(rnd());
  always @(posedge ref_clk) begin
    if (load_valid && load_ready)
      check(load_data, exp_q.size() ? exp_q.pop_front() : 'x);
  end
  // ------------------------------------------
  // sequence
  // ------------------------------------------
  initial begin
    repeat (8) @(negedge ref_clk);
    check(config_ready_n_oe, 1);
    reset = 0;
    wait_on(config_active, 1);
    check(captured_mode, MODE_PAR);
    check(config_ready_n_oe, 0);
    check(config_clock_oe, 0);
    check(handshake_multi_pin_oe, 1);
    mode_select = MODE_MSPI;
    for (int i = 0; i < 6; i++) begin
      b = 8'(rnd());
      wait_on(handshake_multi_pin_out, 0);
      exp_q.push_back(b);
      host.send(b);
      check(config_data_out, 0);
    end
    drain();
    check(data_overrun, 0);
    check(captured_mode, MODE_PAR);
    check(locked_port, PORT_PINS);
    check(config_done_oe, 1);
    load_finished = 1;
    @(negedge ref_clk);
    load_finished = 0;
    wait_on(startup_done, 1);
    check(config_done_oe, 0);
    {user_data_out, user_data_oe, user_hs_out, user_hs_oe, user_so_out,
      user_so_oe} = 20'(rnd());
    @(negedge ref_clk);
    check(config_data_oe, user_data_oe);
    check(serial_out_oe, user_so_oe);
    check(config_data_out, user_data_out);
    check(handshake_multi_pin_out, user_hs_out);
    check(serial_out_or_flash_select, user_so_out);
    program_request_n = 0;
    wait_on(config_ready_n_oe, 1);
    program_request_n = 1;
    wait_on(config_clock_oe, 1);
    check(captured_mode, MODE_MSPI);
    check(serial_out_or_flash_select, 0);
    check(config_data_oe[0], 1);
    check({config_ready_n_out, config_done_out}, 0);
    wait_on(config_clock_out, 1);
    // second reset frees the port lock; one byte comes by test port
    reset = 1;
    repeat (8) @(negedge ref_clk);
    reset = 0;
    b = 8'(rnd());
    exp_q.push_back(b);
    jtag_load(b);
    wait_on(config_active, 1);
    drain();
    check(locked_port, PORT_JTAG);
    check(config_clock_oe, 0);
    check(handshake_multi_pin_oe, user_hs_oe);
    give_verdict();
  end
endmodule : cpc_pin_ctrl_test
